// ==== hdl/cid_core.sv ====
// Executing decoder for control, inherent, pointer and literal operations.
`timescale 1ns/1ps
module cid_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Core side
  input wire logic i_wake,
  output logic o_sleeping,
  output logic o_wdt_kick,
  output logic [7:0] o_prescaler_cfg
);
  // ==========================================================================
  // State
  cid_pkg::cid_state_t state_ff, nxt_state;
  cid_pkg::cid_flags_t flags_ff, nxt_flags;
  logic [13:0] pmem [cid_pkg::PM_DEPTH];
  logic [7:0] dmem [cid_pkg::DM_DEPTH];
  logic [cid_pkg::PC_W-1:0] stack [cid_pkg::STK_DEPTH];
  logic [7:0] dir_ff [8];
  logic [cid_pkg::PC_W-1:0] pc_ff, nxt_pc;
  logic [3:0] sp_ff, nxt_sp;
  logic [7:0] w_ff, nxt_w;
  logic [15:0] ptr0_ff, nxt_ptr0, ptr1_ff, nxt_ptr1;
  logic gie_ff, nxt_gie;
  logic run_ff;
  logic [7:0] pm_addr_ff;
  logic [13:0] instr;
  logic exec, push, dm_we, dir_we, two_cycle, extra, sleep_req, kick, soft_rst, opt_we;
  logic [6:0] dm_wa;
  logic [7:0] dm_wd;
  logic bus_go;

  assign instr = pmem[pc_ff];
  assign exec = (state_ff == cid_pkg::CID_EXEC);

  // ==========================================================================
  // Decode and execute
  always_comb begin
    logic [15:0] ptr, upd, ea;
    logic [7:0] val, andv;
    logic [8:0] sum;
    logic [cid_pkg::PC_W-1:0] ret;
    ptr = instr[2] ? ptr1_ff : ptr0_ff;
    upd = 16'h0000;
    ea = 16'h0000;
    val = 8'h00;
    andv = w_ff & dmem[instr[6:0]];
    sum = {1'b0, w_ff} + {1'b0, instr[7:0]};
    ret = pc_ff + 8'h01;
    nxt_w = w_ff;
    nxt_flags = flags_ff;
    nxt_ptr0 = ptr0_ff;
    nxt_ptr1 = ptr1_ff;
    nxt_pc = ret;
    nxt_sp = sp_ff;
    nxt_gie = gie_ff;
    push = 1'b0;
    dm_we = 1'b0;
    dm_wa = instr[6:0];
    dm_wd = w_ff;
    dir_we = 1'b0;
    opt_we = 1'b0;
    two_cycle = 1'b0;
    extra = 1'b0;
    sleep_req = 1'b0;
    kick = 1'b0;
    soft_rst = 1'b0;
    if (instr == cid_pkg::OP_NOP) begin
      nxt_pc = ret;
    end else if (instr == cid_pkg::OP_SOFT_RESET) begin
      soft_rst = 1'b1;
    end else if (instr == cid_pkg::OP_RETURN || instr == cid_pkg::OP_INTERRUPT_EXIT) begin
      nxt_sp = sp_ff - 4'h1;
      nxt_pc = stack[nxt_sp];
      nxt_gie = gie_ff | instr[0];
      two_cycle = 1'b1;
    end else if (instr == cid_pkg::OP_ACC_CALL) begin
      push = 1'b1;
      nxt_sp = sp_ff + 4'h1;
      nxt_pc = w_ff;
      two_cycle = 1'b1;
    end else if (instr == cid_pkg::OP_ACC_JUMP) begin
      nxt_pc = ret + w_ff;
      two_cycle = 1'b1;
    end else if (instr == cid_pkg::OP_PRESCALER) begin
      opt_we = 1'b1;
    end else if (instr == cid_pkg::OP_SLEEP) begin
      nxt_flags.watchdog_expiry_flag = 1'b1;
      nxt_flags.sleep_entered_flag = 1'b0;
      sleep_req = 1'b1;
    end else if (instr == cid_pkg::OP_WDT_KICK) begin
      nxt_flags.watchdog_expiry_flag = 1'b1;
      nxt_flags.sleep_entered_flag = 1'b1;
      kick = 1'b1;
    end else if (instr[13:3] == cid_pkg::PFX_DIR) begin
      dir_we = 1'b1;
    end else if (instr[13:3] == cid_pkg::PFX_IND_LOAD || instr[13:3] == cid_pkg::PFX_IND_STORE) begin
      // Even mm increments, odd decrements; mm[1] picks post over pre.
      upd = ptr + (instr[0] ? 16'hffff : 16'h0001);
      ea = instr[1] ? ptr : upd;
      if (instr[2]) begin
        nxt_ptr1 = upd;
      end else begin
        nxt_ptr0 = upd;
      end
    end else if (instr[13:8] == cid_pkg::PFX_INDEXED) begin
      ptr = instr[6] ? ptr1_ff : ptr0_ff;
      ea = ptr + {{10{instr[5]}}, instr[5:0]};
    end else if (instr[13:8] == cid_pkg::PFX_PTR_ADD && !instr[7]) begin
      upd = (instr[6] ? ptr1_ff : ptr0_ff) + {{10{instr[5]}}, instr[5:0]};
      if (instr[6]) begin
        nxt_ptr1 = upd;
      end else begin
        nxt_ptr0 = upd;
      end
    end else if (instr[13:8] == cid_pkg::PFX_EXIT_LIT) begin
      nxt_w = instr[7:0];
      nxt_sp = sp_ff - 4'h1;
      nxt_pc = stack[nxt_sp];
      two_cycle = 1'b1;
    end else if (instr[13:8] == cid_pkg::PFX_ADD_LIT) begin
      nxt_w = sum[7:0];
      nxt_flags.c = sum[8];
      nxt_flags.half_carry_flag = ({1'b0, w_ff[3:0]} + {1'b0, instr[3:0]}) > 5'h0f;
      nxt_flags.z = (sum[7:0] == 8'h00);
    end else if (instr[13:8] == cid_pkg::PFX_AND_LIT) begin
      nxt_w = w_ff & instr[7:0];
      nxt_flags.z = ((w_ff & instr[7:0]) == 8'h00);
    end else if (instr[13:8] == cid_pkg::PFX_AND_FILE) begin
      nxt_flags.z = (andv == 8'h00);
      dm_wd = andv;
      if (instr[7]) begin
        dm_we = 1'b1;
      end else begin
        nxt_w = andv;
      end
    end else if (instr[13:9] == cid_pkg::PFX_REL_JUMP) begin
      nxt_pc = ret + instr[7:0];
      two_cycle = 1'b1;
    end else if (instr[13:11] == cid_pkg::PFX_CALL || instr[13:11] == cid_pkg::PFX_ABS_JUMP) begin
      push = !instr[11];
      nxt_sp = instr[11] ? sp_ff : sp_ff + 4'h1;
      nxt_pc = instr[7:0];
      two_cycle = 1'b1;
    end
    // Indirect traffic: upper half of the space reads program memory low bytes.
    if (instr[13:3] == cid_pkg::PFX_IND_LOAD || instr[13:3] == cid_pkg::PFX_IND_STORE
        || instr[13:8] == cid_pkg::PFX_INDEXED) begin
      val = ea[15] ? pmem[ea[7:0]][7:0] : dmem[ea[6:0]];
      extra = ea[15];
      if (instr[13:3] == cid_pkg::PFX_IND_LOAD || (instr[13:8] == cid_pkg::PFX_INDEXED && !instr[7])) begin
        nxt_w = val;
        nxt_flags.z = (val == 8'h00);
      end else begin
        dm_we = !ea[15];
        dm_wa = ea[6:0];
      end
    end
  end

  // ==========================================================================
  // Sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cid_pkg::CID_HALT: begin
        if (run_ff) begin
          nxt_state = cid_pkg::CID_EXEC;
        end
      end
      cid_pkg::CID_EXEC: begin
        if (!run_ff) begin
          nxt_state = cid_pkg::CID_HALT;
        end else if (sleep_req) begin
          nxt_state = cid_pkg::CID_SLEEP;
        end else if (extra) begin
          nxt_state = cid_pkg::CID_EXTRA;
        end else if (two_cycle) begin
          nxt_state = cid_pkg::CID_FLUSH;
        end
      end
      cid_pkg::CID_FLUSH, cid_pkg::CID_EXTRA: begin
        nxt_state = run_ff ? cid_pkg::CID_EXEC : cid_pkg::CID_HALT;
      end
      cid_pkg::CID_SLEEP: begin
        if (i_wake) begin
          nxt_state = cid_pkg::CID_EXEC;
        end
      end
      default: begin
        nxt_state = cid_pkg::CID_HALT;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff <= cid_pkg::CID_HALT;
      o_sleeping <= 1'b0;
      o_wdt_kick <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_sleeping <= (nxt_state == cid_pkg::CID_SLEEP);
      o_wdt_kick <= exec && kick;
    end
  end

  // ==========================================================================
  // Architectural registers
  always_ff @(posedge i_clk) begin
    if (i_srst || (exec && soft_rst)) begin
      pc_ff <= '0;
      sp_ff <= 4'h0;
      w_ff <= cid_pkg::RST_ACC;
      ptr0_ff <= cid_pkg::RST_PTR;
      ptr1_ff <= cid_pkg::RST_PTR;
      gie_ff <= 1'b0;
      flags_ff <= cid_pkg::RST_FLAGS;
      o_prescaler_cfg <= cid_pkg::RST_PRESCALER;
    end else if (exec) begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
      w_ff <= nxt_w;
      ptr0_ff <= nxt_ptr0;
      ptr1_ff <= nxt_ptr1;
      gie_ff <= nxt_gie;
      flags_ff <= nxt_flags;
      if (opt_we) begin
        o_prescaler_cfg <= w_ff;
      end
    end
  end

  // Memories carry no reset; software loads program memory before running.
  always_ff @(posedge i_clk) begin
    if (exec && push) begin
      stack[sp_ff] <= pc_ff + 8'h01;
    end
    if (exec && dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
    if (exec && dir_we) begin
      dir_ff[instr[2:0]] <= w_ff;
    end
    if (bus_go && i_write && i_address == cid_pkg::OFS_PM_DATA) begin
      pmem[pm_addr_ff] <= i_writedata[13:0];
    end
  end

  // ==========================================================================
  // Register bus: one wait cycle, then data stands while waitrequest is low.
  assign bus_go = (i_read || i_write) && !o_waitrequest;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h0000_0000;
      run_ff <= 1'b0;
      pm_addr_ff <= 8'h00;
    end else begin
      o_waitrequest <= !((i_read || i_write) && o_waitrequest);
      if (i_read && o_waitrequest) begin
        if (i_address == cid_pkg::OFS_CTRL) begin
          o_readdata <= {31'h0, run_ff};
        end else if (i_address == cid_pkg::OFS_STATUS) begin
          // State sits in [2:0], the flags in [10:6] and the interrupt enable in [11].
          o_readdata <= {20'h0, gie_ff, flags_ff, 3'h0, state_ff};
        end else if (i_address == cid_pkg::OFS_ACC) begin
          o_readdata <= {24'h0, w_ff};
        end else if (i_address == cid_pkg::OFS_PTR0) begin
          o_readdata <= {16'h0, ptr0_ff};
        end else if (i_address == cid_pkg::OFS_PTR1) begin
          o_readdata <= {16'h0, ptr1_ff};
        end else if (i_address == cid_pkg::OFS_PC) begin
          o_readdata <= {24'h0, pc_ff};
        end else if (i_address == cid_pkg::OFS_PRESCALER) begin
          o_readdata <= {24'h0, o_prescaler_cfg};
        end else if (i_address == cid_pkg::OFS_PM_ADDR) begin
          o_readdata <= {24'h0, pm_addr_ff};
        end else begin
          o_readdata <= 32'h0000_0000;
        end
      end
      if (bus_go && i_write && i_address == cid_pkg::OFS_CTRL) begin
        run_ff <= i_writedata[cid_pkg::CTRL_RUN_BIT];
      end
      if (bus_go && i_write && i_address == cid_pkg::OFS_PM_ADDR) begin
        pm_addr_ff <= i_writedata[7:0];
      end else if (bus_go && i_write && i_address == cid_pkg::OFS_PM_DATA) begin
        pm_addr_ff <= pm_addr_ff + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_jump_flush: assert property (exec && run_ff && two_cycle && !extra |=>
    state_ff == cid_pkg::CID_FLUSH ##1 pc_ff == $past(pc_ff))
    else $error("jump did not take a no-operation second cycle");
  a_extra_cycle: assert property (exec && run_ff && extra |=> state_ff == cid_pkg::CID_EXTRA)
    else $error("upper indirect access did not stall one cycle");
  a_acc_jump: assert property (exec && instr == cid_pkg::OP_ACC_JUMP |=>
    pc_ff == $past(pc_ff) + 8'h01 + $past(w_ff))
    else $error("accumulator jump target wrong");
  a_acc_call: assert property (exec && instr == cid_pkg::OP_ACC_CALL |=>
    pc_ff == $past(w_ff) && sp_ff == $past(sp_ff) + 4'h1)
    else $error("accumulator call target or push wrong");
  a_exit_literal: assert property (exec && instr[13:8] == cid_pkg::PFX_EXIT_LIT |=>
    w_ff == $past(instr[7:0]) && sp_ff == $past(sp_ff) - 4'h1)
    else $error("exit with literal wrong");
  a_sleep_entry: assert property (exec && run_ff && instr == cid_pkg::OP_SLEEP |=>
    o_sleeping && flags_ff.watchdog_expiry_flag && !flags_ff.sleep_entered_flag)
    else $error("sleep entry or flags wrong");
  a_prescaler_copy: assert property (exec && instr == cid_pkg::OP_PRESCALER |=>
    o_prescaler_cfg == $past(w_ff))
    else $error("prescaler copy wrong");
  a_ptr_add_wrap: assert property (exec && instr[13:7] == {cid_pkg::PFX_PTR_ADD, 1'b0} && !instr[6] |=>
    ptr0_ff == $past(ptr0_ff) + {{10{$past(instr[5])}}, $past(instr[5:0])} && $stable(flags_ff))
    else $error("pointer add wrong or flags touched");
  a_add_literal: assert property (exec && instr[13:8] == cid_pkg::PFX_ADD_LIT |=>
    {flags_ff.c, w_ff} == {1'b0, $past(w_ff)} + {1'b0, $past(instr[7:0])} && flags_ff.z == (w_ff == 8'h00))
    else $error("add literal result or flags wrong");
  a_and_literal: assert property (exec && instr[13:8] == cid_pkg::PFX_AND_LIT |=>
    w_ff == ($past(w_ff) & $past(instr[7:0])) && flags_ff.c == $past(flags_ff.c))
    else $error("and literal wrong");
  a_bus_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus answer late");
  // Exact inherent codes share the direction prefix, so their low bits are left out here.
  a_dir_copy: assert property (exec && instr[13:3] == cid_pkg::PFX_DIR && instr[2:1] != 2'b01 &&
    instr[2:0] != 3'h4 |=> dir_ff[$past(instr[2:0])] == $past(w_ff))
    else $error("direction register copy wrong");
  a_soft_reset: assert property (exec && instr == cid_pkg::OP_SOFT_RESET |=>
    pc_ff == '0 && w_ff == cid_pkg::RST_ACC && flags_ff == cid_pkg::RST_FLAGS)
    else $error("software reset did not clear the core");

  c_exit_literal: cover property (exec && instr[13:8] == cid_pkg::PFX_EXIT_LIT ##1 state_ff == cid_pkg::CID_FLUSH);
  c_upper_load: cover property (exec && extra ##1 state_ff == cid_pkg::CID_EXTRA);
  c_sleep_wake: cover property (o_sleeping ##1 i_wake ##1 exec);
  c_soft_reset: cover property (exec && instr == cid_pkg::OP_SOFT_RESET);
endmodule : cid_core

// ==== pkg/cid_pkg.sv ====
// Shared constants and types for the control and indirect operation decoder.
package cid_pkg;
  // ==========================================================================
  // Sizes and register map
  localparam int unsigned PC_W = 8;
  localparam int unsigned PM_DEPTH = 256;
  localparam int unsigned DM_DEPTH = 128;
  localparam int unsigned STK_DEPTH = 16;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_ACC = 6'h08;
  localparam logic [5:0] OFS_PTR0 = 6'h0c;
  localparam logic [5:0] OFS_PTR1 = 6'h10;
  localparam logic [5:0] OFS_PC = 6'h14;
  localparam logic [5:0] OFS_PRESCALER = 6'h18;
  localparam logic [5:0] OFS_PM_ADDR = 6'h1c;
  localparam logic [5:0] OFS_PM_DATA = 6'h20;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [7:0] RST_PRESCALER = 8'hff;
  // ==========================================================================
  // Exact opcodes
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_SOFT_RESET = 14'h0001;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_INTERRUPT_EXIT = 14'h0009;
  localparam logic [13:0] OP_ACC_CALL = 14'h000a;
  localparam logic [13:0] OP_ACC_JUMP = 14'h000b;
  localparam logic [13:0] OP_PRESCALER = 14'h0062;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] OP_WDT_KICK = 14'h0064;
  // ==========================================================================
  // Opcode prefixes
  localparam logic [10:0] PFX_DIR = 11'h00c;
  localparam logic [10:0] PFX_IND_LOAD = 11'h002;
  localparam logic [10:0] PFX_IND_STORE = 11'h003;
  localparam logic [5:0] PFX_EXIT_LIT = 6'h34;
  localparam logic [5:0] PFX_PTR_ADD = 6'h31;
  localparam logic [5:0] PFX_ADD_LIT = 6'h3e;
  localparam logic [5:0] PFX_AND_LIT = 6'h39;
  localparam logic [5:0] PFX_INDEXED = 6'h3f;
  localparam logic [5:0] PFX_AND_FILE = 6'h05;
  localparam logic [4:0] PFX_REL_JUMP = 5'h19;
  localparam logic [2:0] PFX_CALL = 3'h4;
  localparam logic [2:0] PFX_ABS_JUMP = 3'h5;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } cid_flags_t;

  localparam cid_flags_t RST_FLAGS = 5'h18;

  typedef enum logic [2:0] {
    CID_HALT,
    CID_EXEC,
    CID_FLUSH,
    CID_EXTRA,
    CID_SLEEP
  } cid_state_t;
endpackage : cid_pkg

// ==== tb/tb_top.sv ====
// Self-checking bench for the control and indirect operation decoder.
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals and instance
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [5:0] i_address = 6'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic i_wake = 1'b0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_sleeping;
  logic o_wdt_kick;
  logic [7:0] o_prescaler_cfg;
  int num_errors = 0;
  int n_checks = 0;
  int kicks = 0;
  int base = 0;
  integer seed = 32'hb9534a65;

  cid_core DUT (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .i_wake(i_wake),
    .o_sleeping(o_sleeping),
    .o_wdt_kick(o_wdt_kick),
    .o_prescaler_cfg(o_prescaler_cfg)
  );

  always #20 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_wdt_kick === 1'b1) kicks++;
  end

  // ==========================================================================
  // Opcode builders and expectations
  function automatic logic [13:0] lit(input logic [5:0] pfx, input logic [7:0] k);
    return {pfx, k};
  endfunction : lit

  function automatic logic [13:0] ptr(input logic n, input logic [5:0] k);
    return {cid_pkg::PFX_PTR_ADD, 1'b0, n, k};
  endfunction : ptr

  function automatic logic [13:0] idx(input logic s, input logic n, input logic [5:0] k);
    return {cid_pkg::PFX_INDEXED, s, n, k};
  endfunction : idx

  function automatic logic [13:0] ind(input logic s, input logic n, input logic [1:0] mm);
    return {(s ? cid_pkg::PFX_IND_STORE : cid_pkg::PFX_IND_LOAD), n, mm};
  endfunction : ind

  function automatic logic [13:0] andf(input logic d, input logic [6:0] f);
    return {cid_pkg::PFX_AND_FILE, d, f};
  endfunction : andf

  // Status word as seen while asleep: expiry set, sleep-entered cleared.
  function automatic logic [31:0] st(input logic gie, input logic z, input logic dc, input logic c);
    return {20'h0, gie, 1'b1, 1'b0, z, dc, c, 3'h0, 3'h4};
  endfunction : st

  function automatic logic [1:0] addf(input logic [7:0] a, input logic [7:0] b);
    return {({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, ({1'b0, a} + {1'b0, b}) > 9'h0ff};
  endfunction : addf

  // ==========================================================================
  // Bus, run and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One edge passes before each request so a release never meets a new raise.
  // A slave that never answers is left to the watchdog, which ends the run.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    i_address <= a;
    i_write <= wr;
    i_read <= ~wr;
    i_writedata <= d;
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd_chk

  // Cycle counts are taken relative to a lone sleep, so fixed start-up latency cancels out.
  task automatic run(input logic [13:0] p[$], output int cyc);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    wr(cid_pkg::OFS_PM_ADDR, 32'h0);
    foreach (p[i]) wr(cid_pkg::OFS_PM_DATA, {18'h0, p[i]});
    wr(cid_pkg::OFS_CTRL, 32'h1);
    cyc = 0;
    while (o_sleeping !== 1'b1 && cyc < 300) begin
      @(posedge i_clk);
      cyc++;
    end
  endtask : run

  task automatic prog_chk(input logic [13:0] p[$], input int cost, input logic [7:0] w, input logic [31:0] s);
    int cyc;
    run(p, cyc);
    check(32'(cyc - base), 32'(cost));
    rd_chk(cid_pkg::OFS_ACC, {24'h0, w});
    rd_chk(cid_pkg::OFS_STATUS, s);
  endtask : prog_chk

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Scenarios
  initial begin
    logic [7:0] a, b, m, v, e, x;
    logic [5:0] k;
    logic [1:0] f;
    int cyc;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    rd_chk(cid_pkg::OFS_STATUS, 32'h0000_0600);
    check({24'h0, o_prescaler_cfg}, 32'h0000_00ff);
    rd_chk(6'h3c, 32'h0);
    wr(cid_pkg::OFS_ACC, 32'h55);
    rd_chk(cid_pkg::OFS_ACC, 32'h0);
    run('{cid_pkg::OP_SLEEP}, base);
    rd_chk(cid_pkg::OFS_STATUS, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{cid_pkg::OP_NOP, cid_pkg::OP_SLEEP, lit(cid_pkg::PFX_ADD_LIT, 8'h09), cid_pkg::OP_SLEEP},
             1, 8'h00, st(1'b0, 1'b0, 1'b0, 1'b0));
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    cyc = 0;
    while (o_sleeping === 1'b1 && cyc < 50) begin
      @(posedge i_clk);
      cyc++;
    end
    while (o_sleeping !== 1'b1 && cyc < 50) begin
      @(posedge i_clk);
      cyc++;
    end
    rd_chk(cid_pkg::OFS_ACC, 32'h09);
    prog_chk('{{cid_pkg::PFX_ABS_JUMP, 11'h002}, lit(cid_pkg::PFX_ADD_LIT, 8'h01), cid_pkg::OP_SLEEP},
             2, 8'h00, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{{cid_pkg::PFX_REL_JUMP, 9'h001}, lit(cid_pkg::PFX_ADD_LIT, 8'h01), cid_pkg::OP_SLEEP},
             2, 8'h00, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{lit(cid_pkg::PFX_ADD_LIT, 8'h01), cid_pkg::OP_ACC_JUMP, lit(cid_pkg::PFX_ADD_LIT, 8'h02),
               cid_pkg::OP_SLEEP}, 3, 8'h01, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{{cid_pkg::PFX_CALL, 11'h003}, cid_pkg::OP_SLEEP, cid_pkg::OP_NOP, lit(cid_pkg::PFX_ADD_LIT, 8'h05),
               cid_pkg::OP_RETURN}, 5, 8'h05, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{lit(cid_pkg::PFX_ADD_LIT, 8'h03), cid_pkg::OP_ACC_CALL, cid_pkg::OP_SLEEP,
               lit(cid_pkg::PFX_ADD_LIT, 8'h04), cid_pkg::OP_RETURN}, 6, 8'h07, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{{cid_pkg::PFX_CALL, 11'h002}, cid_pkg::OP_SLEEP, lit(cid_pkg::PFX_EXIT_LIT, 8'h5a)},
             4, 8'h5a, st(1'b0, 1'b0, 1'b0, 1'b0));
    prog_chk('{{cid_pkg::PFX_CALL, 11'h002}, cid_pkg::OP_SLEEP, cid_pkg::OP_INTERRUPT_EXIT},
             4, 8'h00, st(1'b1, 1'b0, 1'b0, 1'b0));
    prog_chk('{ptr(1'b0, 6'h3f), idx(1'b1, 1'b0, 6'h00), cid_pkg::OP_SLEEP},
             3, 8'h00, st(1'b0, 1'b0, 1'b0, 1'b0));
    rd_chk(cid_pkg::OFS_PTR0, 32'h0000_ffff);
    prog_chk('{ptr(1'b0, 6'h3f), idx(1'b1, 1'b0, 6'h01), cid_pkg::OP_SLEEP},
             2, 8'h00, st(1'b0, 1'b0, 1'b0, 1'b0));
    a = 8'($random(seed));
    kicks = 0;
    prog_chk('{lit(cid_pkg::PFX_ADD_LIT, a), cid_pkg::OP_PRESCALER, {cid_pkg::PFX_DIR, 3'h5}, cid_pkg::OP_WDT_KICK,
               cid_pkg::OP_SLEEP}, 4, a, st(1'b0, a == 8'h00, 1'b0, 1'b0));
    check({24'h0, o_prescaler_cfg}, {24'h0, a});
    check(32'(kicks), 32'h1);
    for (int t = 0; t < 5; t++) begin
      a = (t == 0) ? 8'hff : 8'($random(seed));
      b = (t == 0) ? 8'h01 : 8'($random(seed));
      m = (t == 0) ? 8'hff : 8'($random(seed));
      k = (t == 0) ? 6'h1f : 6'($random(seed));
      f = addf(a, b);
      x = (a + b) & m;
      prog_chk('{lit(cid_pkg::PFX_ADD_LIT, a), lit(cid_pkg::PFX_ADD_LIT, b), ptr(1'b1, k), ptr(1'b0, 6'h20),
                 lit(cid_pkg::PFX_AND_LIT, m), cid_pkg::OP_SLEEP}, 5, x, st(1'b0, x == 8'h00, f[1], f[0]));
      rd_chk(cid_pkg::OFS_PTR1, {16'h0, {10{k[5]}}, k});
      rd_chk(cid_pkg::OFS_PTR0, 32'h0000_ffe0);
      v = 8'($random(seed));
      e = 8'($random(seed));
      f = addf(v, e);
      x = v & (v + e);
      prog_chk('{lit(cid_pkg::PFX_ADD_LIT, v), ptr(1'b0, 6'h05), ind(1'b1, 1'b0, 2'b10), lit(cid_pkg::PFX_ADD_LIT, e),
                 ind(1'b1, 1'b0, 2'b00), lit(cid_pkg::PFX_AND_LIT, 8'h00), ind(1'b0, 1'b0, 2'b11), andf(1'b0, 7'h05),
                 ind(1'b0, 1'b0, 2'b01), andf(1'b1, 7'h07), idx(1'b0, 1'b0, 6'h02), cid_pkg::OP_SLEEP},
               11, x, st(1'b0, x == 8'h00, f[1], f[0]));
      rd_chk(cid_pkg::OFS_PTR0, 32'h0000_0005);
    end
    // Data byte 0 holds zero here; the first pass stores 3 there, so the pass after the soft reset jumps to sleep.
    prog_chk('{idx(1'b0, 1'b0, 6'h00), cid_pkg::OP_ACC_JUMP, lit(cid_pkg::PFX_ADD_LIT, 8'h03),
               idx(1'b1, 1'b0, 6'h00), cid_pkg::OP_SOFT_RESET, cid_pkg::OP_SLEEP},
             9, 8'h03, st(1'b0, 1'b0, 1'b0, 1'b0));
    wrap_up();
  end

  // A hung handshake ends the run here; a core that never sleeps is cut off by the 300-cycle limit in run.
  initial begin
    #(40 * 20000);
    num_errors++;
    wrap_up();
  end
endmodule : tb_top
